// ### rtl/xdata_sfr_defs.vh
// Constants for the special-function-register bank and external address logic
`ifndef XDATA_SFR_DEFS_VH
`define XDATA_SFR_DEFS_VH

// SFR offsets (8-bit SFR address space)
`define SFR_DPL0        8'h82
`define SFR_DPH0        8'h83
`define SFR_DPL1        8'h84
`define SFR_DPH1        8'h85
`define SFR_DPSEL       8'h86
`define SFR_PTR0_EXT    8'h93
`define SFR_PTR1_EXT    8'h95
`define SFR_IND_PAGE    8'hA0
`define SFR_IRQ_EN      8'hA8
`define SFR_IND_EXT     8'hEA

// Fast port SFR offsets: data, pin state, source select per port
`define SFR_P0_BASE     8'h80
`define SFR_P1_BASE     8'h90
`define SFR_P2_BASE     8'h98
`define SFR_P3_BASE     8'hB0
`define SFR_P4_BASE     8'hC0
`define SFR_P5_BASE     8'hC8
`define SFR_P6_BASE     8'hD8
`define SFR_P12_BASE    8'hE8
`define SFR_P15_BASE    8'hF8
`define SFR_P0_SEL      8'h8A
`define SFR_P1_SEL      8'hA2
`define SFR_P12_SEL     8'hF2
`define OFS_PIN_STATE   8'h01
`define OFS_SRC_SEL     8'h02

// Field positions and reset values
`define DPSEL_BIT       0
`define ALL_IRQ_EN_BIT  7
`define STOP_BIT        0
`define DBG_HALT_BIT    1
`define BYTE_RESET      8'h00
`define WORD_RESET      16'h0000
`define PC_RESET        16'h0000
`define NUM_FAST_PORTS  9

// External move kinds
`define XMOVE_PTR       1'b0
`define XMOVE_IND       1'b1

`endif

// ### rtl/fast_port_lane.v
// One fast-path port: output data, source select and pin state registers
`include "xdata_sfr_defs.vh"

module fast_port_lane
#(
   parameter [7:0] DATA_ADDR = `SFR_P0_BASE,
   parameter [7:0] SEL_ADDR  = `SFR_P0_BASE + `OFS_SRC_SEL
)
(
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // SFR bus
   input  wire [7:0] sfr_addr,
   input  wire [7:0] sfr_wdata,
   input  wire       sfr_wr,
   // Port side
   input  wire [7:0] port_logic_out,
   input  wire [7:0] pins_in,
   output wire [7:0] pin_drive,
   output reg  [7:0] rd_data,
   output wire       rd_hit
);

   reg [7:0] fast_port_output_data_ff;  // Fast-path output data
   reg [7:0] fast_port_source_select_ff; // Per-pin source select
   reg [7:0] sync1_ff;                   // Pin synchroniser stage 1
   reg [7:0] sync2_ff;                   // Stage 2
   reg [7:0] sync3_ff;                   // Stage 3
   reg [7:0] pin_state_ff;               // Filtered pin state

   wire [7:0] ps_addr;
   assign ps_addr = DATA_ADDR + `OFS_PIN_STATE;

   // --------------------------------------------------------------
   // Register writes and pin sampling
   // --------------------------------------------------------------
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fast_port_output_data_ff   <= `BYTE_RESET;
         fast_port_source_select_ff <= `BYTE_RESET;
         sync1_ff                   <= `BYTE_RESET;
         sync2_ff                   <= `BYTE_RESET;
         sync3_ff                   <= `BYTE_RESET;
         pin_state_ff               <= `BYTE_RESET;
      end
      else
      begin
         // Writes to data and select; pin state is read-only
         if (sfr_wr && sfr_addr == DATA_ADDR)
            fast_port_output_data_ff <= sfr_wdata;
         if (sfr_wr && sfr_addr == SEL_ADDR)
            fast_port_source_select_ff <= sfr_wdata;
         sync1_ff <= pins_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         // Accept a bit change once stages two and three agree
         pin_state_ff <= (sync2_ff & sync3_ff) | (pin_state_ff & (sync2_ff | sync3_ff));
      end
   end

   // Source mux per pin: set bit picks fast path
   assign pin_drive = (fast_port_source_select_ff & fast_port_output_data_ff)
                    | (~fast_port_source_select_ff & port_logic_out);

   // --------------------------------------------------------------
   // Read mux
   // --------------------------------------------------------------
   assign rd_hit = (sfr_addr == DATA_ADDR) || (sfr_addr == SEL_ADDR) || (sfr_addr == ps_addr);

   always @*
   begin
      if (sfr_addr == DATA_ADDR)
         rd_data = fast_port_output_data_ff;
      else if (sfr_addr == SEL_ADDR)
         rd_data = fast_port_source_select_ff;
      else if (sfr_addr == ps_addr)
         rd_data = pin_state_ff;
      else
         rd_data = `BYTE_RESET;
   end

endmodule

// ### rtl/halt_ctrl.v
// CPU halt source combiner: boot, stop bit and debugger
`include "xdata_sfr_defs.vh"

module halt_ctrl
(
   // Clock and reset
   input  wire clk,
   input  wire nrst,
   // Sources
   input  wire boot_halt,
   input  wire stop_set,
   input  wire stop_clear,
   input  wire dbg_enable,
   input  wire dbg_wr,
   input  wire [7:0] dbg_wdata,
   // Results
   output reg  stop_ff,
   output reg  dbg_halt_ff,
   output wire cpu_halt
);

   reg boot_done_ff; // Boot finished since reset

   // --------------------------------------------------------------
   // Halt state
   // --------------------------------------------------------------
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stop_ff      <= 1'b0;
         dbg_halt_ff  <= 1'b0;
         boot_done_ff <= 1'b0;
      end
      else
      begin
         // Boot done latches when boot releases halt
         if (!boot_halt)
            boot_done_ff <= 1'b1;
         // Set wins over clear
         if (stop_set)
            stop_ff <= 1'b1;
         else if (stop_clear)
            stop_ff <= 1'b0;
         // Debug halt request only while debugger enabled
         if (!dbg_enable)
            dbg_halt_ff <= 1'b0;
         else if (dbg_wr)
            dbg_halt_ff <= dbg_wdata[`DBG_HALT_BIT];
      end
   end

   assign cpu_halt = !boot_done_ff || boot_halt || stop_ff || dbg_halt_ff;

endmodule

// ### rtl/xdata_addr_ext_port_sfr.v
// SFR bank: data pointers, 24-bit external address, fast ports, halt sources
//
// Contract
// - select bit picks pointer for pointer instructions
// - select zero uses pointer zero, else one
// - four extension registers reset to zero, RW
// - pointer-zero moves take upper byte from extension0
// - pointer-one moves take upper byte from extension1
// - indirect moves take upper byte from indirect extension
// - indirect moves take middle byte from page
// - fast registers for nine ports, three each
// - select bit set drives fast data out
// - pin state read-only, shows current pins; here it shows pins once sync stages two and three agree
// - hub bus keeps full port access alongside
// - interrupt enable bit seven gates all interrupts
// - program space 16-bit, code-read only data
// - program counter resets to zero, runs there
// - external space 16 MB, moves only
// - internal data 256 bytes, SFR area 128
// - CPU halted until boot completes
// - stop bit halts until cleared
// - debugger write to bit one requests halt
`include "xdata_sfr_defs.vh"

module xdata_addr_ext_port_sfr
(
   // Clock and reset
   input  wire        REF_CLK,
   input  wire        NRST,
   // Core SFR bus
   input  wire [7:0]  SFR_ADDR,
   input  wire [7:0]  SFR_WDATA,
   input  wire        SFR_WR,
   input  wire        SFR_RD,
   output reg  [7:0]  SFR_RDATA,
   // Core pointer operations
   input  wire        PTR_INC,
   input  wire        PTR_LOAD16,
   input  wire [15:0] PTR_LOAD_VALUE,
   input  wire [7:0]  ACC_VALUE,
   output wire [15:0] ACTIVE_DATA_POINTER,
   output wire [15:0] CODE_INDEX_ADDR,
   // External data move request
   input  wire        XMOVE_REQ,
   input  wire        XMOVE_KIND,
   input  wire [7:0]  WORK_REG_VALUE,
   output reg  [23:0] EXTERNAL_DATA_ADDRESS,
   output reg         EXTERNAL_DATA_VALID,
   // Fast port path (nine ports, byte each, port 0 in low byte)
   input  wire [71:0] PORT_LOGIC_OUTPUT_DATA,
   input  wire [71:0] PORT_PINS_IN,
   output wire [71:0] PORT_PIN_DRIVE,
   // Interrupt enable
   output wire        ALL_INTERRUPTS_ENABLE,
   // Halt sources
   input  wire        BOOT_HALT,
   input  wire        STOP_SET,
   input  wire        STOP_CLEAR,
   input  wire        DEBUG_ENABLE,
   input  wire        DEBUG_CTRL_WR,
   input  wire [7:0]  DEBUG_CTRL_WDATA,
   output wire        CPU_HALT,
   output wire        CPU_STOPPED,
   output wire        DEBUG_HALT_REQ,
   // Program counter reset value
   output wire [15:0] PROGRAM_COUNTER_RESET
);

   // --------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------
   reg [15:0] data_pointer_zero_ff;            // Pointer zero
   reg [15:0] data_pointer_one_ff;             // Pointer one
   reg        dp_select_ff;                    // Pointer select bit
   reg [7:0]  pointer0_upper_extension_ff;     // Upper byte, pointer zero moves
   reg [7:0]  pointer1_upper_extension_ff;     // Upper byte, pointer one moves
   reg [7:0]  indirect_move_page_ff;           // Middle byte, indirect moves
   reg [7:0]  indirect_move_upper_extension_ff; // Upper byte, indirect moves
   reg [7:0]  interrupt_global_enable_ff;      // Interrupt enable register

   wire [15:0] active_data_pointer;            // Selected pointer
   wire [15:0] nxt_active_pointer;             // Value after inc/load
   wire [7:0]  active_extension;               // Upper byte for pointer moves

   // Fast port lane wiring
   wire [71:0] lane_rdata;
   wire [8:0]  lane_hit;
   reg  [7:0]  lane_mux;
   integer     i;

   // Halt wiring
   wire stop_bit;
   wire dbg_halt;

   // --------------------------------------------------------------
   // Pointer selection
   // --------------------------------------------------------------
   // Zero picks pointer zero, one picks pointer one
   assign active_data_pointer = dp_select_ff ? data_pointer_one_ff
                                             : data_pointer_zero_ff;
   assign active_extension    = dp_select_ff ? pointer1_upper_extension_ff
                                             : pointer0_upper_extension_ff;
   assign ACTIVE_DATA_POINTER = active_data_pointer;
   // Code-space indexed reads and jumps use ACC plus active pointer
   assign CODE_INDEX_ADDR     = active_data_pointer + {8'h00, ACC_VALUE};
   // Increment or 16-bit load applies to active pointer only
   assign nxt_active_pointer  = PTR_LOAD16 ? PTR_LOAD_VALUE
                                           : active_data_pointer + 16'h0001;

   // --------------------------------------------------------------
   // Register writes
   // --------------------------------------------------------------
   always @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         data_pointer_zero_ff             <= `WORD_RESET;
         data_pointer_one_ff              <= `WORD_RESET;
         dp_select_ff                     <= 1'b0;
         pointer0_upper_extension_ff      <= `BYTE_RESET;
         pointer1_upper_extension_ff      <= `BYTE_RESET;
         indirect_move_page_ff            <= `BYTE_RESET;
         indirect_move_upper_extension_ff <= `BYTE_RESET;
         interrupt_global_enable_ff       <= `BYTE_RESET;
      end
      else
      begin
         // Core pointer ops win over SFR writes to either pointer in the same cycle
         if (PTR_INC || PTR_LOAD16)
         begin
            if (dp_select_ff)
               data_pointer_one_ff <= nxt_active_pointer;
            else
               data_pointer_zero_ff <= nxt_active_pointer;
         end
         else if (SFR_WR)
         begin
            // Byte writes into pointer halves
            case (SFR_ADDR)
               `SFR_DPL0: data_pointer_zero_ff[7:0]  <= SFR_WDATA;
               `SFR_DPH0: data_pointer_zero_ff[15:8] <= SFR_WDATA;
               `SFR_DPL1: data_pointer_one_ff[7:0]   <= SFR_WDATA;
               `SFR_DPH1: data_pointer_one_ff[15:8]  <= SFR_WDATA;
               default:   data_pointer_zero_ff       <= data_pointer_zero_ff;
            endcase
         end
         if (SFR_WR)
         begin
            // Remaining registers
            case (SFR_ADDR)
               `SFR_DPSEL:    dp_select_ff <= SFR_WDATA[`DPSEL_BIT];
               `SFR_PTR0_EXT: pointer0_upper_extension_ff <= SFR_WDATA;
               `SFR_PTR1_EXT: pointer1_upper_extension_ff <= SFR_WDATA;
               `SFR_IND_PAGE: indirect_move_page_ff <= SFR_WDATA;
               `SFR_IND_EXT:  indirect_move_upper_extension_ff <= SFR_WDATA;
               `SFR_IRQ_EN:   interrupt_global_enable_ff <= SFR_WDATA;
               default:       dp_select_ff <= dp_select_ff;
            endcase
         end
      end
   end

   // Global enable from bit seven
   assign ALL_INTERRUPTS_ENABLE = interrupt_global_enable_ff[`ALL_IRQ_EN_BIT];

   // --------------------------------------------------------------
   // External data address
   // --------------------------------------------------------------
   // Address registered on each move request; 24 bits span 16 MB
   always @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         EXTERNAL_DATA_ADDRESS <= {`BYTE_RESET, `WORD_RESET};
         EXTERNAL_DATA_VALID   <= 1'b0;
      end
      else
      begin
         EXTERNAL_DATA_VALID <= XMOVE_REQ;
         if (XMOVE_REQ)
         begin
            if (XMOVE_KIND == `XMOVE_IND)
               // Indirect through working register 0 or 1
               EXTERNAL_DATA_ADDRESS <= {indirect_move_upper_extension_ff,
                                         indirect_move_page_ff,
                                         WORK_REG_VALUE};
            else
               // Through active pointer with its own extension
               EXTERNAL_DATA_ADDRESS <= {active_extension,
                                         active_data_pointer};
         end
      end
   end

   // --------------------------------------------------------------
   // Fast port lanes
   // --------------------------------------------------------------
   // Hub bus access to ports lives in the port logic and is untouched here
   fast_port_lane #(.DATA_ADDR(`SFR_P0_BASE), .SEL_ADDR(`SFR_P0_SEL)) u_p0 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[7:0]),
      .pins_in(PORT_PINS_IN[7:0]), .pin_drive(PORT_PIN_DRIVE[7:0]),
      .rd_data(lane_rdata[7:0]), .rd_hit(lane_hit[0]));
   fast_port_lane #(.DATA_ADDR(`SFR_P1_BASE), .SEL_ADDR(`SFR_P1_SEL)) u_p1 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[15:8]),
      .pins_in(PORT_PINS_IN[15:8]), .pin_drive(PORT_PIN_DRIVE[15:8]),
      .rd_data(lane_rdata[15:8]), .rd_hit(lane_hit[1]));
   fast_port_lane #(.DATA_ADDR(`SFR_P2_BASE),
                    .SEL_ADDR(`SFR_P2_BASE + `OFS_SRC_SEL)) u_p2 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[23:16]),
      .pins_in(PORT_PINS_IN[23:16]), .pin_drive(PORT_PIN_DRIVE[23:16]),
      .rd_data(lane_rdata[23:16]), .rd_hit(lane_hit[2]));
   fast_port_lane #(.DATA_ADDR(`SFR_P3_BASE),
                    .SEL_ADDR(`SFR_P3_BASE + `OFS_SRC_SEL)) u_p3 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[31:24]),
      .pins_in(PORT_PINS_IN[31:24]), .pin_drive(PORT_PIN_DRIVE[31:24]),
      .rd_data(lane_rdata[31:24]), .rd_hit(lane_hit[3]));
   fast_port_lane #(.DATA_ADDR(`SFR_P4_BASE),
                    .SEL_ADDR(`SFR_P4_BASE + `OFS_SRC_SEL)) u_p4 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[39:32]),
      .pins_in(PORT_PINS_IN[39:32]), .pin_drive(PORT_PIN_DRIVE[39:32]),
      .rd_data(lane_rdata[39:32]), .rd_hit(lane_hit[4]));
   fast_port_lane #(.DATA_ADDR(`SFR_P5_BASE),
                    .SEL_ADDR(`SFR_P5_BASE + `OFS_SRC_SEL)) u_p5 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[47:40]),
      .pins_in(PORT_PINS_IN[47:40]), .pin_drive(PORT_PIN_DRIVE[47:40]),
      .rd_data(lane_rdata[47:40]), .rd_hit(lane_hit[5]));
   fast_port_lane #(.DATA_ADDR(`SFR_P6_BASE),
                    .SEL_ADDR(`SFR_P6_BASE + `OFS_SRC_SEL)) u_p6 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[55:48]),
      .pins_in(PORT_PINS_IN[55:48]), .pin_drive(PORT_PIN_DRIVE[55:48]),
      .rd_data(lane_rdata[55:48]), .rd_hit(lane_hit[6]));
   fast_port_lane #(.DATA_ADDR(`SFR_P12_BASE), .SEL_ADDR(`SFR_P12_SEL)) u_p12 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[63:56]),
      .pins_in(PORT_PINS_IN[63:56]), .pin_drive(PORT_PIN_DRIVE[63:56]),
      .rd_data(lane_rdata[63:56]), .rd_hit(lane_hit[7]));
   fast_port_lane #(.DATA_ADDR(`SFR_P15_BASE),
                    .SEL_ADDR(`SFR_P15_BASE + `OFS_SRC_SEL)) u_p15 (
      .clk(REF_CLK), .nrst(NRST), .sfr_addr(SFR_ADDR), .sfr_wdata(SFR_WDATA),
      .sfr_wr(SFR_WR), .port_logic_out(PORT_LOGIC_OUTPUT_DATA[71:64]),
      .pins_in(PORT_PINS_IN[71:64]), .pin_drive(PORT_PIN_DRIVE[71:64]),
      .rd_data(lane_rdata[71:64]), .rd_hit(lane_hit[8]));

   // --------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------
   // OR of lane reads; each lane returns zero when not addressed
   always @*
   begin
      lane_mux = `BYTE_RESET;
      for (i = 0; i < `NUM_FAST_PORTS; i = i + 1)
         lane_mux = lane_mux | lane_rdata[i*8 +: 8];
   end

   // Unmapped addresses read zero; reserved select bits read zero
   always @*
   begin
      if (!SFR_RD)
         SFR_RDATA = `BYTE_RESET;
      else
      begin
         // Register area sits in the upper half of the byte address space
         case (SFR_ADDR)
            `SFR_DPL0:     SFR_RDATA = data_pointer_zero_ff[7:0];
            `SFR_DPH0:     SFR_RDATA = data_pointer_zero_ff[15:8];
            `SFR_DPL1:     SFR_RDATA = data_pointer_one_ff[7:0];
            `SFR_DPH1:     SFR_RDATA = data_pointer_one_ff[15:8];
            `SFR_DPSEL:    SFR_RDATA = {7'h00, dp_select_ff};
            `SFR_PTR0_EXT: SFR_RDATA = pointer0_upper_extension_ff;
            `SFR_PTR1_EXT: SFR_RDATA = pointer1_upper_extension_ff;
            `SFR_IND_PAGE: SFR_RDATA = indirect_move_page_ff;
            `SFR_IND_EXT:  SFR_RDATA = indirect_move_upper_extension_ff;
            `SFR_IRQ_EN:   SFR_RDATA = interrupt_global_enable_ff;
            default:       SFR_RDATA = (|lane_hit) ? lane_mux : `BYTE_RESET;
         endcase
      end
   end

   // --------------------------------------------------------------
   // Halt sources and program counter start
   // --------------------------------------------------------------
   halt_ctrl u_halt (
      .clk(REF_CLK), .nrst(NRST), .boot_halt(BOOT_HALT), .stop_set(STOP_SET),
      .stop_clear(STOP_CLEAR), .dbg_enable(DEBUG_ENABLE), .dbg_wr(DEBUG_CTRL_WR),
      .dbg_wdata(DEBUG_CTRL_WDATA), .stop_ff(stop_bit), .dbg_halt_ff(dbg_halt),
      .cpu_halt(CPU_HALT));
   assign CPU_STOPPED    = stop_bit;
   assign DEBUG_HALT_REQ = dbg_halt;
   // Execution begins at zero with no vector table jump
   assign PROGRAM_COUNTER_RESET = `PC_RESET;

endmodule

// ### verification/xdata_addr_ext_port_sfr_properties.sv
// Checker for external addressing, pointer operations and halt sources
module xdata_addr_ext_port_sfr_properties
(
   input logic        REF_CLK,
   input logic        NRST,
   input logic        SFR_WR,
   input logic        PTR_INC,
   input logic        PTR_LOAD16,
   input logic [15:0] PTR_LOAD_VALUE,
   input logic [7:0]  ACC_VALUE,
   input logic [15:0] ACTIVE_DATA_POINTER,
   input logic [15:0] CODE_INDEX_ADDR,
   input logic        XMOVE_REQ,
   input logic        XMOVE_KIND,
   input logic [7:0]  WORK_REG_VALUE,
   input logic [23:0] EXTERNAL_DATA_ADDRESS,
   input logic        EXTERNAL_DATA_VALID,
   input logic        BOOT_HALT,
   input logic        STOP_SET,
   input logic        STOP_CLEAR,
   input logic        DEBUG_ENABLE,
   input logic        DEBUG_CTRL_WR,
   input logic [7:0]  DEBUG_CTRL_WDATA,
   input logic        CPU_HALT,
   input logic        CPU_STOPPED,
   input logic        DEBUG_HALT_REQ
);
   timeunit 1ns;
   timeprecision 1ns;
   //----------------------------------------
   // Properties
   //----------------------------------------
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   // A move request answered one cycle later
   sequence s_move;
      XMOVE_REQ ##1 EXTERNAL_DATA_VALID;
   endsequence
   a_move_answer: assert property (XMOVE_REQ |-> s_move)
      else $error("move not answered");
   a_valid_cause: assert property (EXTERNAL_DATA_VALID |-> $past(XMOVE_REQ))
      else $error("valid without request");
   a_ptr_low: assert property (XMOVE_REQ && !XMOVE_KIND |=>
      EXTERNAL_DATA_ADDRESS[15:0] == $past(ACTIVE_DATA_POINTER)) else $error("bad pointer bits");
   a_ind_low: assert property (XMOVE_REQ && XMOVE_KIND |=>
      EXTERNAL_DATA_ADDRESS[7:0] == $past(WORK_REG_VALUE)) else $error("bad indirect bits");
   a_code_index: assert property (CODE_INDEX_ADDR == ACTIVE_DATA_POINTER + {8'h00, ACC_VALUE})
      else $error("bad code index");
   a_ptr_inc: assert property (PTR_INC && !PTR_LOAD16 && !SFR_WR |=>
      ACTIVE_DATA_POINTER == $past(ACTIVE_DATA_POINTER) + 16'h0001) else $error("no increment");
   a_ptr_load: assert property (PTR_LOAD16 && !SFR_WR |=>
      ACTIVE_DATA_POINTER == $past(PTR_LOAD_VALUE)) else $error("no load");
   a_boot_halt: assert property (BOOT_HALT |-> CPU_HALT)
      else $error("runs during boot");
   a_stop_set: assert property (STOP_SET |=> CPU_STOPPED && CPU_HALT)
      else $error("stop ignored");
   a_stop_hold: assert property (CPU_STOPPED && !STOP_CLEAR |=> CPU_STOPPED)
      else $error("stop lost");
   a_dbg_req: assert property (DEBUG_ENABLE && DEBUG_CTRL_WR |=>
      DEBUG_HALT_REQ == $past(DEBUG_CTRL_WDATA[1])) else $error("debug halt wrong");
endmodule
bind xdata_addr_ext_port_sfr xdata_addr_ext_port_sfr_properties u_props (.*);

// ### verification/port_pin_model.sv
// Port logic and pad model beyond the fast port path
module port_pin_model
(
   input  logic        clk,
   input  logic        load,
   input  logic [71:0] load_val,
   input  logic [71:0] drive,
   output logic [71:0] port_out = '0,
   output logic [71:0] pins = '0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Port logic output register, written from the hub side
   always @(posedge clk)
      if (load)
         port_out <= load_val;
   // Pads follow the drive one clock late
   always @(posedge clk)
      pins <= drive;
endmodule

// ### verification/xdata_addr_ext_port_sfr_tb.sv
// Self-checking bench for the SFR bank, external addressing and fast ports
module xdata_addr_ext_port_sfr_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic REF_CLK = 0, NRST = 0, SFR_WR = 0, SFR_RD = 0, PTR_INC = 0, PTR_LOAD16 = 0, ld = 1;
   logic XMOVE_REQ = 0, XMOVE_KIND = 0, BOOT_HALT = 1, STOP_SET = 0, STOP_CLEAR = 0;
   logic DEBUG_ENABLE = 0, DEBUG_CTRL_WR = 0, EXTERNAL_DATA_VALID, ALL_INTERRUPTS_ENABLE;
   logic CPU_HALT, CPU_STOPPED, DEBUG_HALT_REQ;
   logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0, ACC_VALUE = 0, WORK_REG_VALUE = 0, SFR_RDATA;
   logic [7:0] DEBUG_CTRL_WDATA = 0, q, k, sel, e[5];
   logic [15:0] PTR_LOAD_VALUE = 0, ACTIVE_DATA_POINTER, CODE_INDEX_ADDR, PROGRAM_COUNTER_RESET, p[2];
   logic [23:0] EXTERNAL_DATA_ADDRESS;
   logic [71:0] PORT_LOGIC_OUTPUT_DATA, PORT_PINS_IN, PORT_PIN_DRIVE, lv = 0;
   logic [7:0] rg[5] = '{8'h93, 8'h95, 8'hA0, 8'hA8, 8'hEA};
   logic [7:0] base[9] = '{8'h80, 8'h90, 8'h98, 8'hB0, 8'hC0, 8'hC8, 8'hD8, 8'hE8, 8'hF8};
   logic [7:0] sa[9] = '{8'h8A, 8'hA2, 8'h9A, 8'hB2, 8'hC2, 8'hCA, 8'hDA, 8'hF2, 8'hFA};
   integer seed = 53110, n_errors = 0, tests_run = 0, i;
   always #50 REF_CLK = ~REF_CLK;
   xdata_addr_ext_port_sfr DUT (.*);
   port_pin_model u_pins (.clk(REF_CLK), .load(ld), .load_val(lv), .drive(PORT_PIN_DRIVE),
      .port_out(PORT_LOGIC_OUTPUT_DATA), .pins(PORT_PINS_IN));
   //----------------------------------------
   // Tasks and expectations
   //----------------------------------------
   task chk(input logic [31:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One register bus cycle, launched at the falling edge
   task bus(input logic [7:0] a, d, input logic w, r);
      @(negedge REF_CLK);
      {SFR_ADDR, SFR_WDATA, SFR_WR, SFR_RD} = {a, d, w, r};
      @(posedge REF_CLK);
   endtask
   function automatic logic [7:0] drv(input logic [7:0] d, s, l);
      return (d & s) | (l & ~s);
   endfunction
   task results;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   //----------------------------------------
   // Main sequence
   //----------------------------------------
   initial
   begin
      repeat (9) lv = {lv[63:0], 8'($random(seed))};
      repeat (4) @(posedge REF_CLK);
      @(negedge REF_CLK);
      {NRST, ld} = 2'b10;
      chk({CPU_HALT, PROGRAM_COUNTER_RESET}, 24'h010000);
      for (i = 0; i < 5; i++)
      begin
         bus(rg[i], 8'h00, 0, 1);
         chk(SFR_RDATA, 8'h00);
         e[i] = $random(seed);
         bus(rg[i], e[i], 1, 0);
         bus(rg[i], 8'h00, 0, 1);
         chk({SFR_RDATA, ALL_INTERRUPTS_ENABLE}, {e[i], (i == 3) ? e[3][7] : e[3][7] & (i > 3)});
      end
      bus(8'hB8, 8'h5A, 1, 1);
      chk({SFR_RDATA, CPU_HALT}, 9'h001);
      @(negedge REF_CLK) BOOT_HALT = 0;
      for (k = 0; k < 2; k++)
      begin
         p[k] = $random(seed);
         bus(8'h82 + k + k, p[k][7:0], 1, 0);
         bus(8'h83 + k + k, p[k][15:8], 1, 0);
      end
      for (k = 0; k < 2; k++)
      begin
         bus(8'h86, 8'hFE | k, 1, 0);
         bus(8'h86, 8'h00, 0, 1);
         chk({SFR_RDATA, ACTIVE_DATA_POINTER, CPU_HALT}, {k, p[k], 1'b0});
         @(negedge REF_CLK);
         {XMOVE_REQ, XMOVE_KIND} = 2'b10;
         @(negedge REF_CLK);
         {XMOVE_KIND, WORK_REG_VALUE} = {1'b1, 8'($random(seed))};
         chk({EXTERNAL_DATA_VALID, EXTERNAL_DATA_ADDRESS}, {1'b1, e[k], p[k]});
         @(negedge REF_CLK);
         XMOVE_REQ = 0;
         chk(EXTERNAL_DATA_ADDRESS, {e[4], e[2], WORK_REG_VALUE});
      end
      {PTR_LOAD16, PTR_LOAD_VALUE, ACC_VALUE} = {1'b1, 16'hFFFF, 8'($random(seed))};
      @(negedge REF_CLK);
      {PTR_LOAD16, PTR_INC} = 2'b01;
      @(negedge REF_CLK);
      PTR_INC = 0;
      chk(CODE_INDEX_ADDR, {8'h00, ACC_VALUE});
      bus(8'h82, 8'h00, 0, 1);
      chk(SFR_RDATA, p[0][7:0]);
      for (i = 0; i < 9; i++)
      begin
         sel = (i < 2) ? {8{i[0]}} : 8'($random(seed));
         q = drv(e[i % 5] ^ 8'h3C, sel, lv[8*i +: 8]);
         bus(base[i], e[i % 5] ^ 8'h3C, 1, 0);
         bus(sa[i], sel, 1, 0);
         bus(base[i] + 8'h01, ~q, 1, 0);
         chk(PORT_PIN_DRIVE[8*i +: 8], q);
         for (k = 0; k < 8 && (k == 0 || SFR_RDATA !== q); k++) bus(base[i] + 8'h01, 8'h00, 0, 1);
         chk(SFR_RDATA, q);
      end
      @(negedge REF_CLK) STOP_SET = 1;
      repeat (3) @(negedge REF_CLK);
      STOP_CLEAR = 1;
      @(negedge REF_CLK);
      STOP_SET = 0;
      chk({CPU_STOPPED, CPU_HALT}, 2'b11);
      @(negedge REF_CLK);
      {STOP_CLEAR, DEBUG_ENABLE, DEBUG_CTRL_WR, DEBUG_CTRL_WDATA} = {3'b001, 8'h02};
      chk({CPU_STOPPED, CPU_HALT}, 2'b00);
      @(negedge REF_CLK);
      {DEBUG_ENABLE, DEBUG_CTRL_WR} = 2'b11;
      chk(DEBUG_HALT_REQ, 1'b0);
      @(negedge REF_CLK);
      {DEBUG_ENABLE, DEBUG_CTRL_WR} = 2'b00;
      chk({DEBUG_HALT_REQ, CPU_HALT}, 2'b11);
      @(negedge REF_CLK);
      chk(DEBUG_HALT_REQ, 1'b0);
      results;
   end
   // Hang guard
   initial
   begin
      #1000000;
      n_errors++;
      results;
   end
endmodule
